// File: logic/eag_effective_address_generator.sv
// Effective address generator: operand source select and address sum
//
// Operation
// RL1 - Address is base plus scaled index plus displacement
// RL2 - Index scaled by one, two, four or eight
// RL3 - Stack pointer never valid as index
// RL4 - Any general register usable as base
// RL5 - Displacement is 8 or 32 bits; code also takes a 16-bit displacement, zero-extended
// RL6 - No added cycles except base plus index
// RL7 - Eleven modes: two operand, nine memory
// RL8 - Register operand sized 8, 16, 32 bits
// RL9 - Immediate operand from instruction, no address
// RL10 - Direct mode offset equals displacement
// RL11 - Register indirect offset is base only
// RL12 - Based offset is base plus displacement
// RL13 - Index offset is index plus displacement
// RL14 - Scaled index plus displacement, no base
// RL15 - Based index: base plus index, no displacement
// RL16 - Base plus scaled index, no displacement
// RL17 - Index plus base plus displacement
// RL18 - Scaled index plus base plus displacement
// RL19 - Linear address adds segment base
// RL20 - Sixteen-bit override faults above 64K limit
// RL21 - Sign extend short displacement, wrap sums
// RL22 - Decoder holds request until accepted
`timescale 1ns/1ps
module eag_effective_address_generator
    import eag_pkg::*;
#(
    parameter int ADDR_W = EAG_AW
) (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    // Request from the decoder
    input  wire logic                  reqValid,
    output logic                       reqReady,
    input  wire logic [3:0]            mode,
    input  wire logic [EAG_SEL_W-1:0]  baseSel,
    input  wire logic [EAG_SEL_W-1:0]  indexSel,
    input  wire logic [1:0]            scaleCode,
    input  wire logic [1:0]            dispSize,
    input  wire logic [31:0]           disp,
    input  wire logic [1:0]            opSize,
    input  wire logic [31:0]           immValue,
    input  wire logic                  addr16,
    // Register file read
    input  wire logic [32*EAG_REG_COUNT-1:0] regFile,
    // Segmentation
    input  wire logic [31:0]           segBase,
    // Result
    output logic                       resValid,
    output logic                       resIsMem,
    output logic [31:0]                operand,
    output logic [EAG_SEL_W-1:0]       regSel,
    output logic [1:0]                 regSize,
    output logic [31:0]                operandOffsetSum,
    output logic [31:0]                linearAddr,
    output logic                       badIndex,
    output logic                       protFault
);

    // Only the 32-bit datapath is built; refuse anything else
    if (ADDR_W != 32) begin : g_aw_check
        $error("eag: only 32-bit addressing supported");
    end

    // ==========================================================
    // Operand gathering
    logic [31:0] baseVal;
    logic [31:0] indexVal;
    logic [31:0] scaledIdx;
    logic [31:0] dispExt;
    logic        useBase;
    logic        useIndex;
    logic        useScale;
    logic        useDisp;
    logic        isMem;
    logic        isImm;
    logic        modeOk;

    assign baseVal  = regFile[32*baseSel +: 32];  // RL4
    assign indexVal = regFile[32*indexSel +: 32];

    always_comb begin
        useBase  = 1'b0;
        useIndex = 1'b0;
        useScale = 1'b0;
        useDisp  = 1'b0;
        isMem    = 1'b1;
        isImm    = 1'b0;
        modeOk   = 1'b1;
        case (mode)  // RL7
            EAG_M_REG:    isMem = 1'b0;  // RL8
            EAG_M_IMM: begin  // RL9
                isMem = 1'b0;
                isImm = 1'b1;
            end
            EAG_M_DIRECT: useDisp = 1'b1;  // RL10
            EAG_M_RIND:   useBase = 1'b1;  // RL11
            EAG_M_BASED: begin  // RL12
                useBase = 1'b1;
                useDisp = 1'b1;
            end
            EAG_M_INDEX: begin  // RL13
                useIndex = 1'b1;
                useDisp  = 1'b1;
            end
            EAG_M_SINDEX: begin  // RL14
                useIndex = 1'b1;
                useScale = 1'b1;
                useDisp  = 1'b1;
            end
            EAG_M_BI: begin  // RL15
                useBase  = 1'b1;
                useIndex = 1'b1;
            end
            EAG_M_BSI: begin  // RL16
                useBase  = 1'b1;
                useIndex = 1'b1;
                useScale = 1'b1;
            end
            EAG_M_BID: begin  // RL17
                useBase  = 1'b1;
                useIndex = 1'b1;
                useDisp  = 1'b1;
            end
            EAG_M_BSID: begin  // RL18
                useBase  = 1'b1;
                useIndex = 1'b1;
                useScale = 1'b1;
                useDisp  = 1'b1;
            end
            default: begin
                isMem  = 1'b0;
                modeOk = 1'b0;
            end
        endcase
    end

    // Shift instead of multiply keeps the index path short
    assign scaledIdx = useScale ? (indexVal << scaleCode) : indexVal;  // RL2

    always_comb begin
        case (dispSize)  // RL5 RL21
            EAG_D8:  dispExt = {{24{disp[7]}}, disp[7:0]};
            EAG_D16: dispExt = {16'h0000, disp[15:0]};
            EAG_D32: dispExt = disp;
            default: dispExt = 32'h00000000;
        endcase
    end

    // ==========================================================
    // Sum; 32-bit targets wrap modulo 2^32
    logic [31:0] sumOffset;
    logic [31:0] sumLinear;
    logic        indexBad;
    logic        limitBad;

    assign sumOffset = (useBase ? baseVal : 32'h00000000)
                     + (useIndex ? scaledIdx : 32'h00000000)
                     + (useDisp ? dispExt : 32'h00000000);  // RL1 RL21
    assign sumLinear = sumOffset + segBase;  // RL19 RL21
    assign indexBad  = useIndex && (indexSel == EAG_SP_SEL);  // RL3
    assign limitBad  = isMem && addr16 && (sumOffset > EAG_LIMIT16);  // RL20

    // ==========================================================
    // Control: base plus index costs one extra clock
    eag_state_t state;
    eag_state_t next_state;
    logic       twoCycle;

    assign twoCycle = useBase && useIndex;  // RL6
    // Decoder holds inputs while waiting
    assign reqReady = (state != EAG_S_WAIT);  // RL22

    always_comb begin
        next_state = state;
        case (state)
            EAG_S_IDLE, EAG_S_DONE: begin
                if (reqValid && twoCycle) begin
                    next_state = EAG_S_WAIT;
                end else if (reqValid) begin
                    next_state = EAG_S_DONE;
                end else begin
                    next_state = EAG_S_IDLE;
                end
            end
            EAG_S_WAIT: next_state = EAG_S_DONE;  // RL6
            default:    next_state = EAG_S_IDLE;
        endcase
    end

    // ==========================================================
    // Result registers
    logic        next_resValid;
    logic        next_resIsMem;
    logic [31:0] next_operand;
    logic [2:0]  next_regSel;
    logic [1:0]  next_regSize;
    logic [31:0] next_offset;
    logic [31:0] next_linear;
    logic        next_badIndex;
    logic        next_protFault;
    logic        capture;

    // Capture on the last cycle of each calculation
    assign capture = (state == EAG_S_WAIT)
                   || (reqValid && reqReady && !twoCycle);

    always_comb begin
        next_resValid  = capture;
        next_resIsMem  = resIsMem;
        next_operand   = operand;
        next_regSel    = regSel;
        next_regSize   = regSize;
        next_offset    = operandOffsetSum;
        next_linear    = linearAddr;
        next_badIndex  = badIndex;
        next_protFault = protFault;
        if (capture) begin
            next_resIsMem  = isMem;
            next_regSel    = baseSel;
            next_regSize   = opSize;  // RL8
            next_badIndex  = indexBad || !modeOk;  // RL3
            next_protFault = limitBad;  // RL20
            // Immediate yields value, no address
            next_operand   = isImm ? immValue : 32'h00000000;  // RL9
            if (mode == EAG_M_REG) begin
                next_operand = baseVal;  // RL8
            end
            next_offset    = isMem ? sumOffset : 32'h00000000;
            next_linear    = isMem ? sumLinear : 32'h00000000;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state            <= EAG_S_IDLE;
            resValid         <= 1'b0;
            resIsMem         <= 1'b0;
            operand          <= 32'h00000000;
            regSel           <= 3'h0;
            regSize          <= 2'h0;
            operandOffsetSum <= 32'h00000000;
            linearAddr       <= 32'h00000000;
            badIndex         <= 1'b0;
            protFault        <= 1'b0;
        end else begin
            state            <= next_state;
            resValid         <= next_resValid;
            resIsMem         <= next_resIsMem;
            operand          <= next_operand;
            regSel           <= next_regSel;
            regSize          <= next_regSize;
            operandOffsetSum <= next_offset;
            linearAddr       <= next_linear;
            badIndex         <= next_badIndex;
            protFault        <= next_protFault;
        end
    end

    // ==========================================================
    // Checks
    single_cycle_a: assert property (@(posedge clock) disable iff (!rst_n)
        reqValid && reqReady && !twoCycle |=> resValid)  // RL6
        else $error("single-component request not done next cycle");

    two_cycle_a: assert property (@(posedge clock) disable iff (!rst_n)
        reqValid && reqReady && twoCycle |=> !resValid ##1 resValid)  // RL6
        else $error("base plus index not done in two cycles");

    sp_index_a: assert property (@(posedge clock) disable iff (!rst_n)
        capture && useIndex && indexSel == EAG_SP_SEL |=> badIndex)  // RL3
        else $error("stack pointer index not flagged");

    linear_sum_a: assert property (@(posedge clock) disable iff (!rst_n)
        resValid && resIsMem
        |-> linearAddr == operandOffsetSum + $past(segBase))  // RL19
        else $error("linear address not offset plus segment base");

    direct_disp_a: assert property (@(posedge clock) disable iff (!rst_n)
        reqValid && reqReady && mode == EAG_M_DIRECT
        |=> operandOffsetSum == $past(dispExt))  // RL10
        else $error("direct offset differs from displacement");

    rind_base_a: assert property (@(posedge clock) disable iff (!rst_n)
        reqValid && reqReady && mode == EAG_M_RIND
        |=> operandOffsetSum == $past(baseVal))  // RL11
        else $error("register indirect offset differs from base");

    imm_noaddr_a: assert property (@(posedge clock) disable iff (!rst_n)
        reqValid && reqReady && mode == EAG_M_IMM
        |=> !resIsMem && operand == $past(immValue))  // RL9
        else $error("immediate operand wrong or address made");

    limit_fault_a: assert property (@(posedge clock) disable iff (!rst_n)
        resValid && resIsMem && !protFault && $past(addr16)
        |-> operandOffsetSum <= EAG_LIMIT16)  // RL20
        else $error("16-bit offset above limit without fault");

endmodule

// File: include/eag_pkg.sv
// Package: modes, selects, sizes and states for the effective address generator
package eag_pkg;

    localparam int EAG_AW        = 32;
    localparam int EAG_REG_COUNT = 8;
    localparam int EAG_SEL_W     = 3;
    localparam logic [2:0] EAG_SP_SEL = 3'h4;
    localparam logic [31:0] EAG_LIMIT16 = 32'h0000ffff;
    localparam int EAG_BI_EXTRA = 1;

    typedef enum logic [3:0] {
        EAG_M_REG    = 4'h0,
        EAG_M_IMM    = 4'h1,
        EAG_M_DIRECT = 4'h2,
        EAG_M_RIND   = 4'h3,
        EAG_M_BASED  = 4'h4,
        EAG_M_INDEX  = 4'h5,
        EAG_M_SINDEX = 4'h6,
        EAG_M_BI     = 4'h7,
        EAG_M_BSI    = 4'h8,
        EAG_M_BID    = 4'h9,
        EAG_M_BSID   = 4'ha
    } eag_mode_t;

    typedef enum logic [1:0] {
        EAG_D0  = 2'h0,
        EAG_D8  = 2'h1,
        EAG_D16 = 2'h2,
        EAG_D32 = 2'h3
    } eag_disp_t;

    typedef enum logic [1:0] {
        EAG_SZ8  = 2'h0,
        EAG_SZ16 = 2'h1,
        EAG_SZ32 = 2'h2
    } eag_size_t;

    typedef enum logic [2:0] {
        EAG_S_IDLE = 3'b001,
        EAG_S_WAIT = 3'b010,
        EAG_S_DONE = 3'b100
    } eag_state_t;

endpackage

// File: bench/eag_operand_source_model.sv
// Register file and segment base model facing the address generator
`timescale 1ns/1ps
module eag_operand_source_model
    import eag_pkg::*;
#(
    parameter logic [31:0] SEG_BASE = 32'hf0000000
) (
    // Register file and segmentation
    output logic [32*EAG_REG_COUNT-1:0] regFile,
    output logic [31:0]                 segBase
);
    // ========================================
    // Contents
    // Distinct large values so that sums wrap past 2^32
    always_comb begin
        for (int r = 0; r < EAG_REG_COUNT; r++) begin
            regFile[32*r +: 32] = 32'h11111111 * 32'(r) + 32'h00000004;
        end
        segBase = SEG_BASE;
    end
endmodule

// File: bench/effective_address_generator_test.sv
// Self-checking testbench of the effective address generator
`timescale 1ns/1ps
module effective_address_generator_test;
    import eag_pkg::*;
    localparam logic [31:0] SEG = 32'hf0000000;
    logic         clock;
    logic         rst_n;
    logic         reqValid;
    logic         reqReady;
    logic [3:0]   mode;
    logic [2:0]   baseSel;
    logic [2:0]   indexSel;
    logic [1:0]   scaleCode;
    logic [1:0]   dispSize;
    logic [31:0]  disp;
    logic [1:0]   opSize;
    logic [31:0]  immValue;
    logic         addr16;
    logic [255:0] regFile;
    logic [31:0]  segBase;
    logic         resValid;
    logic         resIsMem;
    logic [31:0]  operand;
    logic [2:0]   regSel;
    logic [1:0]   regSize;
    logic [31:0]  operandOffsetSum;
    logic [31:0]  linearAddr;
    logic         badIndex;
    logic         protFault;
    int           bad_count;
    int           n_checks;
    int           lat;
    logic         midReady;

    eag_effective_address_generator u_eag_effective_address_generator (
        .clock(clock), .rst_n(rst_n), .reqValid(reqValid),
        .reqReady(reqReady), .mode(mode), .baseSel(baseSel),
        .indexSel(indexSel), .scaleCode(scaleCode), .dispSize(dispSize),
        .disp(disp), .opSize(opSize), .immValue(immValue),
        .addr16(addr16), .regFile(regFile), .segBase(segBase),
        .resValid(resValid), .resIsMem(resIsMem), .operand(operand),
        .regSel(regSel), .regSize(regSize),
        .operandOffsetSum(operandOffsetSum), .linearAddr(linearAddr),
        .badIndex(badIndex), .protFault(protFault));
    eag_operand_source_model #(.SEG_BASE(SEG)) u_eag_operand_source_model (
        .regFile(regFile), .segBase(segBase));

    // ========================================
    // Helpers
    task check(input string name, input logic [31:0] seen,
               input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    function logic [31:0] rv(input logic [2:0] r);
        return 32'h11111111 * 32'(r) + 32'h00000004;
    endfunction

    function logic [31:0] dext(input logic [1:0] ds, input logic [31:0] d);
        case (ds)
            2'h1: return {{24{d[7]}}, d[7:0]};
            2'h2: return {16'h0000, d[15:0]};
            2'h3: return d;
            default: return 32'h0;
        endcase
    endfunction

    function logic [31:0] ea(input logic [3:0] m, input logic [2:0] b, i,
                             input logic [1:0] sc, input logic [31:0] dd);
        case (m)
            4'h2: return dd;
            4'h3: return rv(b);
            4'h4: return rv(b) + dd;
            4'h5: return rv(i) + dd;
            4'h6: return (rv(i) << sc) + dd;
            4'h7: return rv(b) + rv(i);
            4'h8: return rv(b) + (rv(i) << sc);
            4'h9: return rv(b) + rv(i) + dd;
            default: return rv(b) + (rv(i) << sc) + dd;
        endcase
    endfunction

    // Decoder side: fields held until taken, then cycles to result counted
    task request(input logic [3:0] m, input logic [2:0] b, i,
                 input logic [1:0] sc, ds, input logic [31:0] d,
                 input logic a16);
        @(posedge clock);
        reqValid <= 1'b1;
        mode <= m;
        baseSel <= b;
        indexSel <= i;
        scaleCode <= sc;
        dispSize <= ds;
        disp <= d;
        addr16 <= a16;
        // Ready settles just after an edge; the following edge takes
        #1;
        for (lat = 0; lat < 8 && reqReady !== 1'b1; lat++) begin
            @(posedge clock);
            #1;
        end
        @(posedge clock);
        reqValid <= 1'b0;
        #1;
        midReady = reqReady;
        for (lat = 1; lat < 8 && resValid !== 1'b1; lat++) begin
            @(posedge clock);
            #1;
        end
    endtask

    // ========================================
    // Scenarios
    task t_operand_modes;
        for (int sz = 0; sz < 3; sz++) begin
            @(posedge clock);
            opSize <= 2'(sz);
            request(4'(EAG_M_REG), 3'(sz + 4), 3'h0, 2'h0, 2'h0, 32'h0, 1'b0);
            check("reg operand", operand, rv(3'(sz + 4)));
            check("reg select", 32'(regSel), 32'(sz + 4));
            check("reg size", 32'(regSize), 32'(sz));
            check("reg is mem", 32'(resIsMem), 32'h0);
        end
        @(posedge clock);
        immValue <= 32'hcafe0123;
        request(4'(EAG_M_IMM), 3'h1, 3'h2, 2'h0, 2'h3, 32'h55, 1'b0);
        check("imm operand", operand, 32'hcafe0123);
        check("imm is mem", 32'(resIsMem), 32'h0);
        check("imm offset", operandOffsetSum, 32'h0);
    endtask

    task t_memory_modes;
        logic [2:0]  b;
        logic [1:0]  ds;
        logic [31:0] e;
        for (int m = 2; m <= 10; m++) begin
            for (int sc = 0; sc < 4; sc++) begin
                b = (m % 2 == 1) ? EAG_SP_SEL : 3'h7;
                ds = (m == 3 || m == 7 || m == 8) ? 2'h0 : 2'(sc);
                request(4'(m), b, 3'h6, 2'(sc), ds, 32'h87654381, 1'b0);
                e = ea(4'(m), b, 3'h6, 2'(sc), dext(ds, 32'h87654381));
                check("offset", operandOffsetSum, e);
                check("linear", linearAddr, e + SEG);
                check("is mem", 32'(resIsMem), 32'h1);
                check("bad index", 32'(badIndex), 32'h0);
                check("latency", 32'(lat), (m >= 7) ? 32'h2 : 32'h1);
                if (m >= 7) check("mid ready", 32'(midReady), 32'h0);
            end
        end
    endtask

    task t_bad_index_and_fault;
        request(4'(EAG_M_INDEX), 3'h1, EAG_SP_SEL, 2'h0, 2'h1, 32'h4, 1'b0);
        check("sp index", 32'(badIndex), 32'h1);
        request(4'hb, 3'h1, 3'h2, 2'h0, 2'h0, 32'h0, 1'b0);
        check("bad mode", 32'(badIndex), 32'h1);
        check("bad mode mem", 32'(resIsMem), 32'h0);
        request(4'(EAG_M_DIRECT), 3'h0, 3'h0, 2'h0, 2'h3, 32'h00010000, 1'b1);
        check("fault above", 32'(protFault), 32'h1);
        request(4'(EAG_M_DIRECT), 3'h0, 3'h0, 2'h0, 2'h3, 32'h0000ffff, 1'b1);
        check("fault at limit", 32'(protFault), 32'h0);
        request(4'(EAG_M_DIRECT), 3'h0, 3'h0, 2'h0, 2'h3, 32'h00010000, 1'b0);
        check("fault no override", 32'(protFault), 32'h0);
        check("direct offset", operandOffsetSum, 32'h00010000);
    endtask

    // ========================================
    // Clock, reset, sequence, watchdog
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    initial begin
        rst_n = 1'b0;
        reqValid = 1'b0;
        mode = 4'h0;
        baseSel = 3'h0;
        indexSel = 3'h0;
        scaleCode = 2'h0;
        dispSize = 2'h0;
        disp = 32'h0;
        opSize = 2'h0;
        immValue = 32'h0;
        addr16 = 1'b0;
        bad_count = 0;
        n_checks = 0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        check("ready after reset", 32'(reqReady), 32'h1);
        check("valid after reset", 32'(resValid), 32'h0);
        t_operand_modes();
        t_memory_modes();
        t_bad_index_and_fault();
        finish_test();
    end

    // Roughly 50 requests of at most 4 cycles each
    initial begin
        #20000;
        bad_count++;
        finish_test();
    end
endmodule
